// ==== design/brvc_pkg.sv ====
/*
  Constants and carrier types for the step-down rail voltage control register bank.
  Assumes a byte-wide register port driven by the device's serial-port engine.
*/
package brvc_pkg;

  // Register offsets on the byte port
  localparam logic [7:0] RAIL1_OFS  = 8'h20;
  localparam logic [7:0] RAIL2_OFS  = 8'h21;
  localparam logic [7:0] R3DCY_OFS  = 8'h22;
  localparam logic [7:0] R3VID_OFS  = 8'h23;
  localparam logic [7:0] R3SLP_OFS  = 8'h24;

  // Field positions: code bits at 0x20, 0x21, 0x23, 0x24; flag bit at 0x20, 0x21, 0x22, 0x24
  localparam int         CODE_MSB   = 7;
  localparam int         CODE_LSB   = 1;
  localparam int         FLAG_BIT   = 0;

  // Clear value held while reset is low, before the factory image is loaded
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  // Read-only low bit of the third rail code register
  localparam logic       R3VID_RSVD = 1'b0;

  // Step range encodings
  localparam logic       RANGE_10MV = 1'b0;
  localparam logic       RANGE_25MV = 1'b1;

  typedef struct packed {
    logic [7:0] rail1;
    logic [7:0] rail2;
    logic [7:0] rail3_decay;
    logic [7:0] rail3_vid;
    logic [7:0] rail3_sleep;
  } brvc_bank_type;

  typedef struct packed {
    logic [6:0] code;
    logic       passive_decay;
    logic       range_25mv;
  } brvc_rail_cmd_type;

  typedef enum logic [0:0] {
    ST_LOAD = 1'b0,
    ST_RUN  = 1'b1
  } brvc_state_type;

  typedef struct packed {
    brvc_state_type state;
    brvc_bank_type  bank;
    logic [1:0]     range12;
    logic [7:0]     rdata;
    logic           hit;
  } brvc_regs_state_type;

  typedef struct packed {
    brvc_rail_cmd_type cmd;
    logic              down;
  } brvc_drive_state_type;

endpackage : brvc_pkg

// ==== design/brvc_rail_drive.sv ====
/*
  Per-rail command register: presents the applied code, range and down-transition mode
  to the analog loop, and flags each step to a lower code.
  Assumes its inputs are already resolved from the register bank in the same clock domain.
*/
`timescale 1ns/1ps
module brvc_rail_drive (
  input  wire logic                       i_clk,          // 250 MHz clock
  input  wire logic                       i_resetn,       // Synchronous reset, active low
  input  wire logic [6:0]                 i_code,         // Code selected for this rail
  input  wire logic                       i_passive,      // 1: passive decay on a drop
  input  wire logic                       i_range_25mv,   // Step range of the code
  output brvc_pkg::brvc_rail_cmd_type     o_cmd,          // Registered rail command
  output logic                            o_down          // One-cycle pulse: code lowered
);

  brvc_pkg::brvc_drive_state_type s;
  brvc_pkg::brvc_drive_state_type next_s;

  always_comb
  begin
    next_s                   = s;
    next_s.cmd.code          = i_code;
    next_s.cmd.passive_decay = i_passive;
    next_s.cmd.range_25mv    = i_range_25mv;
    // The loop either slews or lets go only when the target falls
    next_s.down              = (i_code < s.cmd.code);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_cmd  = s.cmd;
  assign o_down = s.down;

endmodule : brvc_rail_drive

// ==== design/brvc_regs.sv ====
/*
  Voltage control register bank for three step-down controller rails: normal codes,
  down-transition mode, third-rail sleep code and enable.
  Assumes a byte register port from the serial-port engine (one access per strobe), a
  factory default image stable by reset release, and a sleep pin synchronous to i_clk.
*/
// Operation
// R1: Offset 0x20 bits 7:1 set rail one code
// R2: Offset 0x21 bits 7:1 set rail two code
// R3: Rails one, two use 10 or 25 mV range
// R4: Offset 0x23 bits 7:1 hold rail three code, 25mV
// R5: Decay bit clear slews down, set decays passively
// R6: Rail three decay bit sits at 0x22 bit 0
// R7: Bits 7:1 at 0x22 are inert storage
// R8: Offset 0x24 holds sleep code and enable
// R9: Sleep enabled and pin low selects sleep code
// R10: Power-up loads factory defaults into every register
`timescale 1ns/1ps
module brvc_regs (
  input  wire logic                       i_clk,          // 250 MHz clock
  input  wire logic                       i_resetn,       // Synchronous reset, active low
  input  wire logic [7:0]                 i_reg_addr,     // Register offset
  input  wire logic                       i_reg_wr,       // Write strobe, one cycle
  input  wire logic [7:0]                 i_reg_wdata,    // Write data
  input  wire logic                       i_reg_rd,       // Read strobe, one cycle
  output logic      [7:0]                 o_reg_rdata,    // Read data, registered
  output logic                            o_reg_hit,      // Last access hit a register
  input  brvc_pkg::brvc_bank_type         i_otp_bank,     // Factory default image
  input  wire logic [1:0]                 i_otp_range12,  // Factory range, rails one, two
  input  wire logic                       i_sleep_pin_n,  // Assigned sleep pin, low = sleep
  output logic                            o_ready,        // Defaults loaded, port open
  output brvc_pkg::brvc_rail_cmd_type     o_rail1,        // Rail one command
  output brvc_pkg::brvc_rail_cmd_type     o_rail2,        // Rail two command
  output brvc_pkg::brvc_rail_cmd_type     o_rail3,        // Rail three command
  output logic      [2:0]                 o_rail_down,    // Per-rail code-lowered pulse
  output logic                            o_rail3_sleep   // Rail three on sleep code
);

  brvc_pkg::brvc_regs_state_type s;
  brvc_pkg::brvc_regs_state_type next_s;

  logic [6:0] rail_code    [3];
  logic       rail_passive [3];
  logic       rail_range   [3];
  brvc_pkg::brvc_rail_cmd_type rail_cmd [3];
  logic       sleep_active;
  logic [4:0] reg_sel;
  logic       reg_mapped;
  logic       wr_take;
  logic [7:0] rd_word;

  // One-hot register select; stays zero for any offset outside the bank
  always_comb
  begin
    reg_sel = 5'h00;
    case (i_reg_addr)
      brvc_pkg::RAIL1_OFS:
      begin
        reg_sel[0] = 1'b1;
      end
      brvc_pkg::RAIL2_OFS:
      begin
        reg_sel[1] = 1'b1;
      end
      brvc_pkg::R3DCY_OFS:
      begin
        reg_sel[2] = 1'b1;
      end
      brvc_pkg::R3VID_OFS:
      begin
        reg_sel[3] = 1'b1;
      end
      brvc_pkg::R3SLP_OFS:
      begin
        reg_sel[4] = 1'b1;
      end
      default:
      begin
        reg_sel = 5'h00;
      end
    endcase
  end

  assign reg_mapped = |reg_sel;
  // Writes are refused until the factory image is in, so a host cannot race the load
  assign wr_take    = i_reg_wr && (s.state == brvc_pkg::ST_RUN);

  // Contents of the addressed register; zero where nothing is mapped
  always_comb
  begin
    rd_word = brvc_pkg::RDATA_NONE;
    if (reg_sel[0])
    begin
      rd_word = s.bank.rail1;
    end
    if (reg_sel[1])
    begin
      rd_word = s.bank.rail2;
    end
    if (reg_sel[2])
    begin
      rd_word = s.bank.rail3_decay;
    end
    if (reg_sel[3])
    begin
      rd_word = s.bank.rail3_vid;
    end
    if (reg_sel[4])
    begin
      rd_word = s.bank.rail3_sleep;
    end
  end

  always_comb
  begin
    next_s = s;
    case (s.state)
      brvc_pkg::ST_LOAD:
      begin
        // Reset only clears; the factory image is taken on the first cycle after release
        next_s.bank                                          = i_otp_bank;      // [R10]
        next_s.bank.rail3_vid[brvc_pkg::FLAG_BIT]            = brvc_pkg::R3VID_RSVD;
        next_s.range12                                       = i_otp_range12;   // [R3]
        next_s.state                                         = brvc_pkg::ST_RUN;
      end
      brvc_pkg::ST_RUN:
      begin
        if (wr_take)
        begin
          if (reg_sel[0])
          begin
            next_s.bank.rail1 = i_reg_wdata;                                    // [R1] [R5]
          end
          if (reg_sel[1])
          begin
            next_s.bank.rail2 = i_reg_wdata;                                    // [R2] [R5]
          end
          if (reg_sel[2])
          begin
            next_s.bank.rail3_decay = i_reg_wdata;                              // [R6] [R7]
          end
          if (reg_sel[3])
          begin
            next_s.bank.rail3_vid = {i_reg_wdata[brvc_pkg::CODE_MSB:brvc_pkg::CODE_LSB],
                                     brvc_pkg::R3VID_RSVD};                     // [R4]
          end
          if (reg_sel[4])
          begin
            next_s.bank.rail3_sleep = i_reg_wdata;                              // [R8]
          end
        end
      end
      default:
      begin
        next_s.state = brvc_pkg::ST_LOAD;
      end
    endcase

    if (i_reg_rd || i_reg_wr)
    begin
      next_s.hit   = reg_mapped;                                              // [R8]
      // A lone write answers zero; a read beside a write still shows the old contents
      next_s.rdata = i_reg_rd ? rd_word : brvc_pkg::RDATA_NONE;               // [R7]
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      s.state   <= brvc_pkg::ST_LOAD;
      s.bank    <= {5{brvc_pkg::REG_RESET}};
      s.range12 <= {brvc_pkg::RANGE_10MV, brvc_pkg::RANGE_10MV};
      s.rdata   <= brvc_pkg::RDATA_NONE;
      s.hit     <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Sleep code only while enabled and the pin is held low
  assign sleep_active = s.bank.rail3_sleep[brvc_pkg::FLAG_BIT] && !i_sleep_pin_n;  // [R9]

  always_comb
  begin
    rail_code[0]    = s.bank.rail1[brvc_pkg::CODE_MSB:brvc_pkg::CODE_LSB];          // [R1]
    rail_code[1]    = s.bank.rail2[brvc_pkg::CODE_MSB:brvc_pkg::CODE_LSB];          // [R2]
    rail_code[2]    = sleep_active
                    ? s.bank.rail3_sleep[brvc_pkg::CODE_MSB:brvc_pkg::CODE_LSB]     // [R9]
                    : s.bank.rail3_vid[brvc_pkg::CODE_MSB:brvc_pkg::CODE_LSB];      // [R4]
    rail_passive[0] = s.bank.rail1[brvc_pkg::FLAG_BIT];                             // [R5]
    rail_passive[1] = s.bank.rail2[brvc_pkg::FLAG_BIT];                             // [R5]
    rail_passive[2] = s.bank.rail3_decay[brvc_pkg::FLAG_BIT];                       // [R6]
    rail_range[0]   = s.range12[0];                                                 // [R3]
    rail_range[1]   = s.range12[1];                                                 // [R3]
    rail_range[2]   = brvc_pkg::RANGE_25MV;                                         // [R4]
  end

  // Commands are held at reset values until the image is loaded, so no rail sees zero codes
  // as a target drop after release; the load only raises codes from zero, so it gives no drop pulse.
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_rail
      brvc_rail_drive u_drive (
        .i_clk        (i_clk),
        .i_resetn     (i_resetn),
        .i_code       (rail_code[g]),
        .i_passive    (rail_passive[g]),
        .i_range_25mv (rail_range[g]),
        .o_cmd        (rail_cmd[g]),
        .o_down       (o_rail_down[g])
      );
    end
  endgenerate

  assign o_rail1       = rail_cmd[0];
  assign o_rail2       = rail_cmd[1];
  assign o_rail3       = rail_cmd[2];
  assign o_rail3_sleep = sleep_active;
  assign o_reg_rdata   = s.rdata;
  assign o_reg_hit     = s.hit;
  assign o_ready       = (s.state == brvc_pkg::ST_RUN);

endmodule : brvc_regs

// ==== tb/brvc_regs_properties.sv ====
/* Port checker for the rail voltage control register bank.
   Bound to brvc_regs from the bench; sees only its ports. */
`timescale 1ns/1ps
module brvc_regs_properties (
  input wire logic                  i_clk,         // Clock
  input wire logic                  i_resetn,      // Reset, low
  input wire logic [7:0]            i_reg_addr,    // Offset
  input wire logic                  i_reg_wr,      // Write strobe
  input wire logic [7:0]            i_reg_wdata,   // Write data
  input wire logic                  i_reg_rd,      // Read strobe
  input wire logic [7:0]            o_reg_rdata,   // Read data
  input wire logic                  o_reg_hit,     // Mapped hit
  input wire logic                  i_sleep_pin_n, // Sleep pin
  input wire logic                  o_ready,       // Loaded
  input brvc_pkg::brvc_rail_cmd_type o_rail1,      // Rail one
  input brvc_pkg::brvc_rail_cmd_type o_rail2,      // Rail two
  input brvc_pkg::brvc_rail_cmd_type o_rail3,      // Rail three
  input wire logic [2:0]            o_rail_down,   // Down pulses
  input wire logic                  o_rail3_sleep  // Sleep code used
);
  logic acc;
  logic map;
  assign acc = i_reg_wr || i_reg_rd;
  assign map = (i_reg_addr >= 8'h20) && (i_reg_addr <= 8'h24);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  property p_ready; $rose(i_resetn) |=> o_ready; endproperty
  a_ready: assert property (p_ready) else $error("not ready after load");
  property p_unmap; o_ready && acc && !map |=> !o_reg_hit && o_reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access answered");
  property p_hit; o_ready && acc && map |=> o_reg_hit; endproperty
  a_hit: assert property (p_hit) else $error("mapped access missed");
  property p_r3bit0; i_reg_rd && i_reg_addr == 8'h23 |=> !o_reg_rdata[0]; endproperty
  a_r3bit0: assert property (p_r3bit0) else $error("reserved bit read high");
  property p_rail1;
    o_ready && i_reg_wr && i_reg_addr == 8'h20
      |-> ##2 {o_rail1.code, o_rail1.passive_decay} == $past(i_reg_wdata, 2);
  endproperty
  a_rail1: assert property (p_rail1) else $error("rail one command wrong");
  property p_rail2;
    o_ready && i_reg_wr && i_reg_addr == 8'h21
      |-> ##2 {o_rail2.code, o_rail2.passive_decay} == $past(i_reg_wdata, 2);
  endproperty
  a_rail2: assert property (p_rail2) else $error("rail two command wrong");
  property p_r3dcy;
    o_ready && i_reg_wr && i_reg_addr == 8'h22
      |-> ##2 o_rail3.passive_decay == $past(i_reg_wdata[0], 2);
  endproperty
  a_r3dcy: assert property (p_r3dcy) else $error("rail three decay wrong");
  property p_down; $past(o_ready) && o_rail1.code < $past(o_rail1.code) |-> o_rail_down[0];
  endproperty
  a_down: assert property (p_down) else $error("no down pulse");
  property p_sleep_off; i_sleep_pin_n |-> !o_rail3_sleep; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep without pin");
endmodule : brvc_regs_properties

// ==== tb/brvc_regs_bench.sv ====
/* Self-checking bench for the rail register bank.
   Drives every port itself; the checker is bound at the foot. */
`timescale 1ns/1ps
module brvc_regs_bench;
  logic                        i_clk = 1'b0;
  logic                        i_resetn = 1'b0;
  logic                        i_reg_wr = 1'b0;
  logic                        i_reg_rd = 1'b0;
  logic                        i_sleep_pin_n = 1'b1;
  logic [7:0]                  i_reg_addr = 8'h00;
  logic [7:0]                  i_reg_wdata = 8'h00;
  logic [1:0]                  i_otp_range12 = 2'h2;
  brvc_pkg::brvc_bank_type     i_otp_bank = '0;
  logic [7:0]                  o_reg_rdata;
  logic                        o_reg_hit;
  logic                        o_ready;
  logic                        o_rail3_sleep;
  logic [2:0]                  o_rail_down;
  brvc_pkg::brvc_rail_cmd_type o_rail1;
  brvc_pkg::brvc_rail_cmd_type o_rail2;
  brvc_pkg::brvc_rail_cmd_type o_rail3;
  logic [7:0]                  v [5];
  logic [7:0]                  r;
  logic [31:0]                 t;
  logic [31:0]                 seed = 32'h00005A5A;
  int                          n_fail = 0;
  int                          checked = 0;
  int                          k;
  int                          a;
  always #2 i_clk = ~i_clk;
  brvc_regs brvc_regs_inst (.i_clk, .i_resetn, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .i_reg_rd, .o_reg_rdata, .o_reg_hit, .i_otp_bank, .i_otp_range12, .i_sleep_pin_n,
    .o_ready, .o_rail1, .o_rail2, .o_rail3, .o_rail_down, .o_rail3_sleep);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // The third rail code register never shows its low bit
  function automatic logic [7:0] exp_rd(input int idx, input logic [7:0] d);
    return (idx == 3) ? {d[7:1], 1'b0} : d;
  endfunction : exp_rd
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 r = o_reg_rdata;
  endtask : rd
  task automatic check_all();
    for (int i = 0; i < 5; i++)
    begin
      rd(8'h20 + i[7:0]);
      chk("readback", exp_rd(i, v[i]), r);
      chk("hit", 8'h01, {7'h00, o_reg_hit});
    end
  endtask : check_all
  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial
  begin
    t = xs();
    i_otp_bank <= {t, t[15:8]};
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (k = 0; k < 20 && o_ready !== 1'b1; k++) @(posedge i_clk);
    if (o_ready !== 1'b1)
    begin
      n_fail++;
      wrap_up();
    end
    for (a = 0; a < 5; a++) v[a] = i_otp_bank[39 - 8 * a -: 8];
    check_all();
    chk("range1", 8'h00, {7'h00, o_rail1.range_25mv});
    chk("range2", 8'h01, {7'h00, o_rail2.range_25mv});
    for (k = 0; k < 6; k++)
    begin
      for (a = 0; a < 5; a++)
      begin
        t = xs();
        v[a] = t[7:0];
        wr(8'h20 + a[7:0], v[a]);
      end
      #1;
      chk("rail1", v[0], {o_rail1.code, o_rail1.passive_decay});
      chk("rail2", v[1], {o_rail2.code, o_rail2.passive_decay});
      chk("r3dcy", {7'h00, v[2][0]}, {7'h00, o_rail3.passive_decay});
      chk("r3code", {1'b0, v[3][7:1]}, {1'b0, o_rail3.code});
      chk("r3range", 8'h01, {7'h00, o_rail3.range_25mv});
      check_all();
    end
    for (a = 0; a < 3; a++)
    begin
      // Rails one, two and three sit at 0x20, 0x21 and 0x23
      wr(8'h20 + a[7:0] + {7'h00, a == 2}, 8'hFE);
      wr(8'h20 + a[7:0] + {7'h00, a == 2}, 8'h00);
      @(posedge i_clk);
      #1 chk("down", 8'h01, {7'h00, o_rail_down[a]});
      @(posedge i_clk);
      #1 chk("down_end", 8'h00, {7'h00, o_rail_down[a]});
    end
    wr(8'h25, 8'hFF);
    rd(8'h25);
    chk("unmapped", 8'h00, r);
    chk("unmapped_hit", 8'h00, {7'h00, o_reg_hit});
    wr(8'h23, 8'h60);
    wr(8'h24, 8'h0B);
    i_sleep_pin_n <= 1'b0;
    @(posedge i_clk);
    #1 chk("sleep_code", 8'h05, {1'b0, o_rail3.code});
    chk("sleep_flag", 8'h01, {7'h00, o_rail3_sleep});
    wr(8'h24, 8'h0A);
    @(posedge i_clk);
    #1 chk("wake_code", 8'h30, {1'b0, o_rail3.code});
    chk("wake_flag", 8'h00, {7'h00, o_rail3_sleep});
    wrap_up();
  end
endmodule : brvc_regs_bench
bind brvc_regs brvc_regs_properties brvc_regs_properties_inst (.i_clk, .i_resetn,
  .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_hit,
  .i_sleep_pin_n, .o_ready, .o_rail1, .o_rail2, .o_rail3, .o_rail_down, .o_rail3_sleep);
